/* verilog/pmul_top.sv */
/*
 * 16x16 parallel multiplier with individually strobed operand and product
 * registers, two product output arrangements and three-state outputs.
 * assumes all inputs synchronous to CLK_SYS; register "clocks" arrive as
 * synchronous strobes whose rising edge is detected here.
 * a strobe must be seen low for at least one CLK_SYS sample before its
 * next rise counts; a strobe held high loads only once.
 * products queue in a 16-word fifo between the array and the output
 * registers, so low strobes retire them in the order they were made.
 * the host must release the shared y port whenever Y_OE is high.
 * the fifo storage itself is never cleared; only its pointers and count reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pmul_defs.svh"

// Functional notes
// - multiply 16-bit x by 16-bit y into a full 32-bit product
// - each operand separately chosen as two's complement or unsigned
// - operand and product registers each load on their own strobe
// - every register loads only on the rising edge of its own strobe
// - first arrangement: halves selected one at a time onto dedicated port
// - second arrangement: low half driven onto the shared y port
// - all product outputs can float; host must not drive shared port while Y_OE is high
// - product output registers can be made transparent
module pmul_top (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [`PMUL_OPND_W-1:0] X_IN,
    input wire logic [`PMUL_OPND_W-1:0] Y_IN,
    input wire logic TC_X,
    input wire logic TC_Y,
    input wire logic LOAD_X,
    input wire logic LOAD_Y,
    input wire logic LOAD_HIGH,
    input wire logic LOAD_LOW,
    input wire logic TRANSPARENT,
    input wire logic SEL_HIGH,
    input wire logic SHARE_LOW,
    input wire logic PROD_EN,
    input wire logic SHARE_EN,
    output logic IN_READY,
    output logic PROD_VALID,
    output logic [`PMUL_HALF_W-1:0] PROD_OUT,
    output logic PROD_OE,
    output logic [`PMUL_HALF_W-1:0] Y_OUT,
    output logic Y_OE
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_s1_r, rst_n;

    // two flops so the release never reaches the state close to a clock edge
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // ****************************************
    // strobe edge detection
    // ****************************************
    logic [3:0] strb_r, strb_nxt;
    logic rise_x, rise_y, rise_hi, rise_lo;

    // inputs are synchronous, so the previous sample is enough for an edge
    // limitation: a strobe pulse shorter than one clock period can be missed
    always_comb begin
        strb_nxt = {LOAD_LOW, LOAD_HIGH, LOAD_Y, LOAD_X};
        rise_x = LOAD_X & ~strb_r[0];
        rise_y = LOAD_Y & ~strb_r[1];
        rise_hi = LOAD_HIGH & ~strb_r[2];
        rise_lo = LOAD_LOW & ~strb_r[3];
    end

    // history starts high so a strobe already up at release cannot load
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            strb_r <= 4'hf;
        end else begin
            strb_r <= strb_nxt;
        end
    end

    // ****************************************
    // operand registers
    // ****************************************
    pmul_pkg::pmul_opnd_t x_r, x_nxt, y_r, y_nxt;
    logic pend_r, pend_nxt;
    logic fifo_in_ready, take_x, take_y;
    pmul_pkg::pmul_prod_t prod;
    logic signed [`PMUL_OPND_W:0] x_ext, y_ext;
    logic signed [2*`PMUL_OPND_W+1:0] full_prod;

    // a loaded pair waits one cycle to enter the fifo; loads stall meanwhile.
    // y is refused while the shared port is driven, since it would read back our own bits
    // a full fifo keeps the pair pending, which stalls the host through IN_READY
    always_comb begin
        IN_READY = ~pend_r;
        take_x = rise_x & ~pend_r;
        take_y = rise_y & ~pend_r & ~Y_OE;
        x_nxt = x_r;
        y_nxt = y_r;
        if (take_x) begin
            x_nxt = '{tc: TC_X, val: X_IN};
        end
        if (take_y) begin
            y_nxt = '{tc: TC_Y, val: Y_IN};
        end
        pend_nxt = pend_r;
        if (take_x | take_y) begin
            pend_nxt = 1'b1;
        end else if (fifo_in_ready) begin
            pend_nxt = 1'b0;
        end
    end

    // operands and the pending flag
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            x_r <= '{tc: 1'b0, val: `PMUL_OPND_RST};
            y_r <= '{tc: 1'b0, val: `PMUL_OPND_RST};
            pend_r <= 1'b0;
        end else begin
            x_r <= x_nxt;
            y_r <= y_nxt;
            pend_r <= pend_nxt;
        end
    end

    // ****************************************
    // multiplier array
    // ****************************************
    // one extra bit per operand: sign copy for two's complement, zero for unsigned
    // 17x17 signed never overflows 34 bits; the top two bits only repeat the sign
    always_comb begin
        x_ext = $signed({x_r.tc & x_r.val[`PMUL_OPND_W-1], x_r.val});
        y_ext = $signed({y_r.tc & y_r.val[`PMUL_OPND_W-1], y_r.val});
        full_prod = x_ext * y_ext;
        prod = full_prod[`PMUL_PROD_W-1:0];
    end

    // ****************************************
    // product fifo
    // ****************************************
    pmul_pkg::pmul_prod_t head;
    logic head_valid, pop;

    // decouples the array from the output strobes so products can queue
    pmul_fifo #(
        .WIDTH(`PMUL_PROD_W),
        .DEPTH(`PMUL_FIFO_DEPTH),
        .AW(`PMUL_FIFO_AW)
    ) pmul_fifo_inst (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .in_valid(pend_r),
        .in_ready(fifo_in_ready),
        .in_data(prod),
        .out_valid(head_valid),
        .out_ready(pop),
        .out_data(head)
    );

    // ****************************************
    // product output registers
    // ****************************************
    logic [`PMUL_HALF_W-1:0] hi_r, hi_nxt, lo_r, lo_nxt;
    logic [`PMUL_HALF_W-1:0] hi_q, lo_q;

    // high strobe copies head; low strobe copies head and retires it
    always_comb begin
        pop = rise_lo & head_valid;
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        if (rise_hi & head_valid) begin
            hi_nxt = head.hi;
        end
        if (pop) begin
            lo_nxt = head.lo;
        end
        hi_q = TRANSPARENT ? head.hi : hi_r;
        lo_q = TRANSPARENT ? head.lo : lo_r;
        PROD_VALID = head_valid;
    end

    // output halves
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            hi_r <= `PMUL_HALF_RST;
            lo_r <= `PMUL_HALF_RST;
        end else begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end
    end

    // ****************************************
    // output arrangement and enables
    // ****************************************
    // in shared mode the dedicated port carries only the high half
    always_comb begin
        if (SHARE_LOW) begin
            // low half lives on the shared port, so only the high half is left here
            PROD_OUT = hi_q;
        end else if (SEL_HIGH) begin
            PROD_OUT = hi_q;
        end else begin
            PROD_OUT = lo_q;
        end
        // enables stay low until the internal reset has been released
        PROD_OE = PROD_EN & rst_n;
        Y_OUT = lo_q;
        Y_OE = SHARE_LOW & SHARE_EN & rst_n;
    end

endmodule

`default_nettype wire

/* verilog/pmul_defs.svh */
/*
 * constants of the parallel multiplier: widths, depth, reset values.
 * assumes nothing; definitions only, included by bare name.
 */
`ifndef PMUL_DEFS_SVH
`define PMUL_DEFS_SVH

// ****************************************
// widths and depths
// ****************************************
`define PMUL_OPND_W 16
`define PMUL_HALF_W 16
`define PMUL_PROD_W 32
`define PMUL_FIFO_DEPTH 16
`define PMUL_FIFO_AW 4

// ****************************************
// reset values
// ****************************************
`define PMUL_OPND_RST 16'h0000
`define PMUL_HALF_RST 16'h0000

`endif

/* verilog/pmul_pkg.sv */
/*
 * types used by the multiplier top; its product fifo takes only a plain WIDTH.
 * assumes pmul_defs.svh is on the include path.
 */
`include "pmul_defs.svh"

package pmul_pkg;

    // ****************************************
    // operand and product carriers
    // ****************************************
    typedef struct packed {
        logic tc;
        logic [`PMUL_OPND_W-1:0] val;
    } pmul_opnd_t;

    typedef struct packed {
        logic [`PMUL_HALF_W-1:0] hi;
        logic [`PMUL_HALF_W-1:0] lo;
    } pmul_prod_t;

endpackage

/* verilog/pmul_fifo.sv */
/*
 * synchronous fifo with valid/ready on both sides, honest full and empty.
 * assumes one clock and an active-low asynchronous reset already synchronised.
 */
`timescale 1ns/10ps
`default_nettype none

module pmul_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // ****************************************
    // pointer and count update
    // ****************************************
    always_comb begin
        in_ready = (cnt_r != (AW+1)'(DEPTH)); // full only when every word is taken
        out_valid = (cnt_r != '0);
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        wr_nxt = push ? wr_r + 1'b1 : wr_r;
        rd_nxt = pop ? rd_r + 1'b1 : rd_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        out_data = mem[rd_r];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage has no reset; only written on push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

endmodule

`default_nettype wire

/* test/pmul_top_properties.sv */
/* port assertions of pmul_top.
   assumes it is bound into pmul_top. */
`timescale 1ns/10ps
`default_nettype none
module pmul_top_properties (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic LOAD_X,
    input wire logic LOAD_Y,
    input wire logic LOAD_LOW,
    input wire logic TRANSPARENT,
    input wire logic SHARE_LOW,
    input wire logic PROD_EN,
    input wire logic SHARE_EN,
    input wire logic IN_READY,
    input wire logic PROD_VALID,
    input wire logic PROD_OE,
    input wire logic [15:0] Y_OUT,
    input wire logic Y_OE
);
    // one domain; first edges after release skipped, reset leaves through flops
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    prod_oe_a: assert property ($past(RST_B, 3) |-> PROD_OE == PROD_EN)
        else $error("product enable wrong");
    share_oe_a: assert property ($past(RST_B, 3) |-> Y_OE == (SHARE_LOW && SHARE_EN))
        else $error("shared enable wrong");
    ready_x_a: assert property ($past(RST_B, 3) && $rose(LOAD_X) && IN_READY |=> !IN_READY)
        else $error("x load not taken");
    ready_y_a: assert property ($past(RST_B, 3) && $rose(LOAD_Y) && IN_READY && !Y_OE |=> !IN_READY)
        else $error("y load not taken");
    valid_two_a: assert property ($past(RST_B, 3) && $rose(LOAD_X) && IN_READY && !PROD_VALID
        |=> ##1 PROD_VALID)
        else $error("product late");
    y_refuse_a: assert property (Y_OE && IN_READY && $rose(LOAD_Y) && !$rose(LOAD_X) |=> IN_READY)
        else $error("y loaded while driven");
    low_hold_a: assert property (Y_OE && $past(Y_OE) && !TRANSPARENT && !$past(TRANSPARENT)
        && $past(LOAD_LOW) == $past(LOAD_LOW, 2) |-> $stable(Y_OUT))
        else $error("low half moved");
    empty_pop_a: assert property (!PROD_VALID && $rose(LOAD_LOW) |=> TRANSPARENT || $stable(Y_OUT))
        else $error("empty pop changed low");
endmodule
bind pmul_top pmul_top_properties pmul_top_properties_inst (.*);
`default_nettype wire

/* test/pmul_host_model.sv */
/* host model: supplies operands, never holds the shared y value.
   assumes calls start just after a clock edge. */
`timescale 1ns/10ps
`default_nettype none
module pmul_host_model (
    input wire logic clk,
    output logic [15:0] x,
    output logic [15:0] y,
    output logic tcx,
    output logic tcy,
    output logic ldx,
    output logic ldy
);
    // idle values
    initial begin
        {x, y, tcx, tcy, ldx, ldy} = '0;
    end
    // strobe low again for an edge so the next rise is seen
    task load(input logic [15:0] a, input logic ta, input logic [15:0] b, input logic tb, input logic lx);
        {x, tcx, y, tcy, ldx, ldy} = {a, ta, b, tb, lx, 1'b1};
        @(posedge clk);
        #1;
        {ldx, ldy} = 2'b00;
        y = ~b; // released value differs from the operand
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* test/tb_pmul_top.sv */
/* bench of pmul_top: sign modes, shared port, transparency, full fifo.
   assumes host model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_pmul_top;
    logic CLK_SYS = 1'b0, RST_B = 1'b0, LOAD_HIGH = 1'b0, LOAD_LOW = 1'b0, TRANSPARENT = 1'b0;
    logic SEL_HIGH = 1'b1, SHARE_LOW = 1'b0, PROD_EN = 1'b1, SHARE_EN = 1'b0;
    logic IN_READY, PROD_VALID, PROD_OE, Y_OE, TC_X, TC_Y, LOAD_X, LOAD_Y;
    logic [15:0] X_IN, Y_IN, host_y, PROD_OUT, Y_OUT;
    int num_errors = 0, checks = 0;
    always #2 CLK_SYS = ~CLK_SYS;
    // host lets go of y while the device drives it
    assign Y_IN = Y_OE ? Y_OUT : host_y;
    pmul_host_model pmul_host_model_inst (.clk(CLK_SYS), .x(X_IN), .y(host_y), .tcx(TC_X), .tcy(TC_Y),
        .ldx(LOAD_X), .ldy(LOAD_Y));
    pmul_top pmul_top_inst (.*);
    task cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // bounded wait on ready (v=0) or valid (v=1)
    task wait_for(input logic v);
        int i;
        for (i = 0; i < 60 && (v ? PROD_VALID : IN_READY) !== 1'b1; i++) cyc(1);
        if (i == 60) begin
            num_errors++;
            $display("unexpected at %0t: wait ran out", $time);
        end
    endtask
    // high strobe first, low strobe pops; high half must outlive the pop
    task pop(input logic [31:0] e);
        SEL_HIGH = 1;
        LOAD_HIGH = 1;
        cyc(2);
        LOAD_HIGH = 0;
        LOAD_LOW = 1;
        cyc(2);
        LOAD_LOW = 0;
        cmp(PROD_OUT, e[31:16]);
        SEL_HIGH = 0;
        cyc(1);
        cmp(SHARE_LOW ? Y_OUT : PROD_OUT, e[15:0]);
    endtask
    task run(input logic [15:0] a, input logic ta, input logic [15:0] b, input logic tb);
        logic signed [31:0] sa, sb;
        sa = {{16{ta & a[15]}}, a};
        sb = {{16{tb & b[15]}}, b};
        wait_for(0);
        pmul_host_model_inst.load(a, ta, b, tb, 1);
        wait_for(1);
        pop(sa * sb);
    endtask
    task t_modes;
        logic [15:0] va [4] = '{16'h8000, 16'hffff, 16'h7fff, 16'h1234};
        for (int m = 0; m < 4; m++)
            for (int i = 0; i < 4; i++) run(va[i], m[1], va[3-i], m[0]);
        $display("modes done");
    endtask
    task t_share;
        // y is loaded while the shared port is still released, then the device drives it
        SHARE_LOW = 1;
        run(16'hc001, 1, 16'h0102, 0);
        cmp(PROD_OUT, 16'hffbf);
        SHARE_EN = 1;
        cyc(1);
        cmp(16'(Y_OE), 1);
        cmp(Y_OUT, 16'h8102);
        pmul_host_model_inst.load(16'h0005, 0, 16'h0007, 0, 0);
        cyc(3);
        cmp(16'(IN_READY), 1);
        cmp(16'(PROD_VALID), 0);
        {SHARE_LOW, SHARE_EN, PROD_EN} = 3'b000;
        cyc(1);
        cmp(16'({Y_OE, PROD_OE}), 0);
        PROD_EN = 1;
        $display("share done");
    endtask
    task t_trans;
        wait_for(0);
        pmul_host_model_inst.load(16'h0100, 0, 16'h0302, 0, 1);
        wait_for(1);
        {TRANSPARENT, SEL_HIGH} = 2'b11;
        cyc(1);
        cmp(PROD_OUT, 16'h0003);
        SEL_HIGH = 0;
        cyc(1);
        cmp(PROD_OUT, 16'h0200);
        TRANSPARENT = 0;
        pop(32'h00030200);
        $display("transparent done");
    endtask
    task t_fifo;
        for (int k = 0; k < 17; k++) begin
            wait_for(0);
            pmul_host_model_inst.load(16'(k), 0, 16'h0003, 0, 1);
        end
        cyc(4);
        cmp(16'(IN_READY), 0);
        for (int k = 0; k < 17; k++) begin
            cyc(3);
            pop(32'(k * 3));
        end
        LOAD_LOW = 1;
        cyc(2);
        LOAD_LOW = 0;
        cmp(16'(PROD_VALID), 0);
        $display("fifo done");
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence after 8 cycles of reset
    initial begin
        cyc(8);
        RST_B = 1;
        cyc(3);
        t_modes();
        t_share();
        t_trans();
        t_fifo();
        finish_test();
    end
    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        #20000;
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
